//--- verilog/ptd_pkg.sv
// constants for the processor trap detection and priority unit
// assumes one core clock and a synchronous active-high device reset
//
// What this block does
// - A misaligned word data access, a data access to unimplemented data memory, or a data access to unimplemented program memory raises an address error trap.
// - Any instruction fetch from the trap vector region raises an address error trap.
// - For multiply-accumulate class accesses, all of Y space is unimplemented for X and all of X space is unimplemented for Y.
// - A branch or jump literal whose target is unimplemented program memory raises an address error trap.
// - Executing from an unimplemented program address after the PC changes, including by a return, raises an address error trap.
// - Loading the stack pointer above the stack limit register value raises a stack error trap.
// - Loading the stack pointer below 0x0800 raises a stack error trap.
// - Failure of the external oscillator with fallback to the internal backup raises an oscillator fail trap.
// - Traps active together are serviced in fixed priority order while lower ones stay pending.
// - Levels 8 to 11 are soft traps and the arithmetic error trap is level 11.
// - Levels 12 to 15 are hard traps.
// - Address error is level 12, stack error level 13 and oscillator fail level 14.
// - After a hard trap, code execution is held until that trap is acknowledged.
// - A lower hard trap arising while a higher trap is pending, acknowledged or in service is a conflict.
// - A conflict resets the device and sets the conflict flag at bit 15 of the reset control register.

package ptd_pkg;
  localparam int DADDR_W = 16;
  localparam int PADDR_W = 24;
  localparam int LVL_W = 4;
  localparam int NLVL = 8;
  localparam int IDX_W = 3;
  localparam int RESET_CONTROL_REGISTER_W = 16;

  // priority levels; pending bit index is level minus the soft base
  localparam logic [LVL_W-1:0] LVL_BASE = 4'h8;
  localparam logic [LVL_W-1:0] LVL_ARITH = 4'hB;
  localparam logic [LVL_W-1:0] LVL_ADDR = 4'hC;
  localparam logic [LVL_W-1:0] LVL_STACK = 4'hD;
  localparam logic [LVL_W-1:0] LVL_OSC = 4'hE;
  localparam int IDX_ARITH = 3;
  localparam int IDX_ADDR = 4;
  localparam int IDX_STACK = 5;
  localparam int IDX_OSC = 6;
  localparam int IDX_HARD_LO = 4;
  localparam int IDX_HARD_HI = 7;

  // data space map
  localparam logic [DADDR_W-1:0] STACK_FLOOR = 16'h0800;
  localparam logic [DADDR_W-1:0] X_HI = 16'h0BFF;
  localparam logic [DADDR_W-1:0] Y_LO = 16'h0C00;
  localparam logic [DADDR_W-1:0] Y_HI = 16'h0FFF;
  localparam logic [DADDR_W-1:0] DATA_END = 16'h1000;

  // program space map
  localparam logic [PADDR_W-1:0] PROG_END = 24'h008000;
  localparam logic [PADDR_W-1:0] VEC_LO = 24'h000004;
  localparam logic [PADDR_W-1:0] VEC_HI = 24'h00007F;

  localparam int RESET_CONTROL_REGISTER_CONFLICT_BIT = 15;
  localparam logic [RESET_CONTROL_REGISTER_W-1:0] RESET_CONTROL_REGISTER_RESET = 16'h0000;
  localparam logic [NLVL-1:0] LVL_NONE = 8'h00;
endpackage : ptd_pkg

//--- verilog/ptd_trap_unit.sv
// trap detection, priority resolution and hard trap conflict handling
// assumes the core drives access strobes on ref_clk; osc_fail is asynchronous

`timescale 1ns/1ps

module ptd_trap_unit (
  input wire logic ref_clk, // core clock, 50 MHz
  input wire logic rst, // synchronous device reset, active high
  input wire logic dacc_valid, // data space access this cycle
  input wire logic dacc_word, // access is word sized
  input wire logic [ptd_pkg::DADDR_W-1:0] dacc_addr, // data access byte address
  input wire logic dacc_mac_x, // multiply-accumulate class X access
  input wire logic dacc_mac_y, // multiply-accumulate class Y access
  input wire logic pacc_valid, // data access into program space
  input wire logic [ptd_pkg::PADDR_W-1:0] pacc_addr, // program space data address
  input wire logic ifetch_valid, // instruction fetch this cycle
  input wire logic [ptd_pkg::PADDR_W-1:0] ifetch_addr, // fetch address
  input wire logic bra_lit_valid, // branch_always_literal or jump literal executes
  input wire logic [ptd_pkg::PADDR_W-1:0] bra_lit_target, // literal target
  input wire logic pc_exec_valid, // execution continues after a pc change
  input wire logic [ptd_pkg::PADDR_W-1:0] pc_value, // new pc value
  input wire logic sp_load_valid, // stack pointer loaded
  input wire logic [ptd_pkg::DADDR_W-1:0] sp_value, // value loaded
  input wire logic [ptd_pkg::DADDR_W-1:0] stack_limit_register, // software limit
  input wire logic osc_fail, // clock monitor: running on backup rc
  input wire logic arith_err, // arithmetic error from core
  input wire logic trap_ack, // core acknowledges a trap
  input wire logic [ptd_pkg::LVL_W-1:0] ack_level, // level acknowledged
  input wire logic trap_done, // core finished highest in-service trap
  input wire logic conflict_flag_clr, // software clears the conflict flag
  output logic [ptd_pkg::NLVL-1:0] trap_pending, // pending bits, levels 8..15
  output logic service_req, // a trap is pending
  output logic [ptd_pkg::LVL_W-1:0] service_level, // highest pending level
  output logic core_hold, // block code execution
  output logic conflict_reset, // one-cycle device reset request
  output logic [ptd_pkg::RESET_CONTROL_REGISTER_W-1:0] reset_control_register // reset cause bits
);
  import ptd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic prog_unimpl(input logic [PADDR_W-1:0] a);
    prog_unimpl = (a >= PROG_END);
  endfunction : prog_unimpl

  // highest set bit index; valid only when mask is non-zero
  function automatic logic [IDX_W-1:0] top_idx(input logic [NLVL-1:0] m);
    top_idx = '0;
    for (int i = 0; i < NLVL; i++) begin
      if (m[i]) begin
        top_idx = IDX_W'(i);
      end
    end
  endfunction : top_idx

  function automatic logic [NLVL-1:0] idx_bit(input logic [IDX_W-1:0] i);
    idx_bit = NLVL'(1) << i;
  endfunction : idx_bit

  ////////////////////////////////////////////////////////////////////////////
  // oscillator fail input: three-stage synchroniser and agreement filter

  logic osc_s1, osc_s2, osc_s3, osc_lvl;
  logic next_osc_lvl;
  logic osc_evt;

  always_comb begin
    next_osc_lvl = (osc_s2 == osc_s3) ? osc_s3 : osc_lvl;
    osc_evt = (osc_s2 == osc_s3) && osc_s3 && !osc_lvl;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_lvl <= 1'b0;
    end else begin
      osc_s1 <= osc_fail;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      osc_lvl <= next_osc_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trap cause detection

  logic data_bad, addr_evt, stack_evt;
  logic [NLVL-1:0] new_evt;

  always_comb begin
    if (dacc_mac_x) begin
      data_bad = (dacc_addr > X_HI);
    end else if (dacc_mac_y) begin
      data_bad = (dacc_addr < Y_LO) || (dacc_addr > Y_HI);
    end else begin
      data_bad = (dacc_addr >= DATA_END);
    end
    addr_evt = (dacc_valid && ((dacc_word && dacc_addr[0]) || data_bad))
      || (pacc_valid && prog_unimpl(pacc_addr))
      || (ifetch_valid && ifetch_addr >= VEC_LO && ifetch_addr <= VEC_HI)
      || (bra_lit_valid && prog_unimpl(bra_lit_target))
      || (pc_exec_valid && prog_unimpl(pc_value));
    stack_evt = sp_load_valid
      && ((sp_value > stack_limit_register)
      || (sp_value < STACK_FLOOR));
    new_evt = LVL_NONE;
    new_evt[IDX_ARITH] = arith_err;
    new_evt[IDX_ADDR] = addr_evt;
    new_evt[IDX_STACK] = stack_evt;
    new_evt[IDX_OSC] = osc_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending, in-service, priority and conflict

  logic [NLVL-1:0] in_service;
  logic [NLVL-1:0] next_pending, next_in_service, ack_clr, done_clr, busy;
  logic conflict;
  logic [RESET_CONTROL_REGISTER_W-1:0] next_reset_control_register;
  logic next_service_req, next_core_hold, next_conflict_reset;
  logic [LVL_W-1:0] next_service_level;

  always_comb begin
    ack_clr = trap_ack ? idx_bit(IDX_W'(ack_level - LVL_BASE)) : LVL_NONE;
    done_clr = (trap_done && |in_service) ? idx_bit(top_idx(in_service)) : LVL_NONE;
    busy = trap_pending | in_service;
    conflict = 1'b0;
    for (int i = IDX_HARD_LO; i <= IDX_HARD_HI; i++) begin
      if (new_evt[i] && |(busy >> (i + 1))) begin
        conflict = 1'b1;
      end
    end
    // a new cause wins over an acknowledge in the same cycle
    next_pending = (trap_pending & ~ack_clr) | new_evt;
    next_in_service = ((in_service & ~done_clr) | (ack_clr & trap_pending)) & ~new_evt;
    next_reset_control_register = reset_control_register;
    if (conflict_flag_clr) begin
      next_reset_control_register[RESET_CONTROL_REGISTER_CONFLICT_BIT] = 1'b0;
    end
    if (conflict) begin
      next_pending = LVL_NONE;
      next_in_service = LVL_NONE;
      next_reset_control_register[RESET_CONTROL_REGISTER_CONFLICT_BIT] = 1'b1;
    end
    next_service_req = |next_pending;
    next_service_level = LVL_BASE + LVL_W'(top_idx(next_pending));
    next_core_hold = |next_pending[IDX_HARD_HI:IDX_HARD_LO];
    next_conflict_reset = conflict;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trap_pending <= LVL_NONE;
      in_service <= LVL_NONE;
      service_req <= 1'b0;
      service_level <= LVL_BASE;
      core_hold <= 1'b0;
      conflict_reset <= 1'b0;
      reset_control_register <= RESET_CONTROL_REGISTER_RESET;
    end else begin
      trap_pending <= next_pending;
      in_service <= next_in_service;
      service_req <= next_service_req;
      service_level <= next_service_level;
      core_hold <= next_core_hold;
      conflict_reset <= next_conflict_reset;
      reset_control_register <= next_reset_control_register;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_misalign_trap: assert property (@(posedge ref_clk) disable iff (rst)
    dacc_valid && dacc_word && dacc_addr[0] |=> trap_pending[IDX_ADDR] || conflict_reset)
    else $error("misaligned word access gave no address trap");

  a_vector_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    ifetch_valid && ifetch_addr >= VEC_LO && ifetch_addr <= VEC_HI
    |=> trap_pending[IDX_ADDR] || conflict_reset)
    else $error("vector space fetch gave no address trap");

  a_mac_y_space: assert property (@(posedge ref_clk) disable iff (rst)
    dacc_valid && dacc_mac_x && dacc_addr >= Y_LO && dacc_addr <= Y_HI
    |=> trap_pending[IDX_ADDR] || conflict_reset)
    else $error("x access into y space gave no address trap");

  a_return_pc: assert property (@(posedge ref_clk) disable iff (rst)
    pc_exec_valid && pc_value >= PROG_END |=> trap_pending[IDX_ADDR] || conflict_reset)
    else $error("execution from unimplemented pc gave no trap");

  a_stack_bounds: assert property (@(posedge ref_clk) disable iff (rst)
    sp_load_valid && (sp_value < STACK_FLOOR || sp_value > stack_limit_register)
    |=> trap_pending[IDX_STACK] || conflict_reset)
    else $error("stack bound violation gave no stack trap");

  a_osc_fail_trap: assert property (@(posedge ref_clk) disable iff (rst)
    !osc_lvl && $rose(osc_fail) ##1 osc_fail [*2]
    |-> ##[1:2] (trap_pending[IDX_OSC] || conflict_reset || osc_lvl))
    else $error("oscillator failure gave no trap");

  a_highest_served: assert property (@(posedge ref_clk) disable iff (rst)
    service_req |-> trap_pending[IDX_W'(service_level - LVL_BASE)]
    && (trap_pending >> (IDX_W'(service_level - LVL_BASE) + 1)) == LVL_NONE)
    else $error("service level is not the highest pending");

  a_hard_hold: assert property (@(posedge ref_clk) disable iff (rst)
    core_hold == (|trap_pending[IDX_HARD_HI:IDX_HARD_LO]))
    else $error("hard trap pending without execution hold");

  a_conflict_cause: assert property (@(posedge ref_clk) disable iff (rst)
    stack_evt && (trap_pending[IDX_OSC] || in_service[IDX_OSC])
    |=> conflict_reset ##1 !conflict_reset)
    else $error("hard trap conflict not detected");

  a_conflict_flag: assert property (@(posedge ref_clk) disable iff (rst)
    conflict_reset |-> reset_control_register[RESET_CONTROL_REGISTER_CONFLICT_BIT]
    && trap_pending == LVL_NONE && in_service == LVL_NONE)
    else $error("conflict reset without flag or with trap state left");
endmodule : ptd_trap_unit

//--- verification/ptd_core_model.sv
// core-side model for the trap unit: acknowledges and retires traps on request
// assumes the bench raises auto_ack while the core should service pending traps

`timescale 1ns/1ps

module ptd_core_model (
  input wire logic ref_clk, // core clock
  input wire logic rst, // device reset
  input wire logic auto_ack, // bench lets the core service traps
  input wire logic service_req, // a trap is pending
  input wire logic [ptd_pkg::LVL_W-1:0] service_level, // highest pending level
  output logic trap_ack, // acknowledge pulse
  output logic [ptd_pkg::LVL_W-1:0] ack_level, // level acknowledged
  output logic trap_done // end of service pulse
);
  import ptd_pkg::*;

  initial begin
    trap_ack = 1'b0;
    ack_level = LVL_BASE;
    trap_done = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ack the highest pending level, retire it the next cycle; pulses move on
  // the falling edge so they are stable at the sampling edge
  always @(negedge ref_clk) begin
    trap_done <= trap_ack;
    trap_ack <= 1'b0;
    if (!rst && auto_ack && service_req && !trap_ack && !trap_done) begin
      trap_ack <= 1'b1;
      ack_level <= service_level;
    end
  end
endmodule : ptd_core_model

//--- verification/tb.sv
// self-checking bench for the trap detection and priority unit
// assumes ptd_pkg is compiled first and the core model answers acknowledges

`timescale 1ns/1ps

module tb;
  import ptd_pkg::*;
  logic ref_clk, rst, dacc_valid, dacc_word, dacc_mac_x, dacc_mac_y, pacc_valid;
  logic ifetch_valid, bra_lit_valid, pc_exec_valid, sp_load_valid, osc_fail, arith_err;
  logic conflict_flag_clr, auto_ack, trap_ack, trap_done, service_req, core_hold;
  logic conflict_reset;
  logic [15:0] dacc_addr, sp_value, stack_limit_register, reset_control_register;
  logic [23:0] pacc_addr, ifetch_addr, bra_lit_target, pc_value;
  logic [3:0] ack_level, service_level;
  logic [7:0] trap_pending;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int kk[19] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 7, 8, 8, 8, 8, 9};
  logic [23:0] aa[19] = '{24'h000801, 24'h000800, 24'h000801, 24'h001000, 24'h000C00,
    24'h000BFE, 24'h000BFE, 24'h000C00, 24'h008000, 24'h007FFE, 24'h000004, 24'h000080,
    24'h008000, 24'h008002, 24'h0007FE, 24'h000A02, 24'h000A00, 24'h000800, 24'h000000};
  logic [7:0] pp[19] = '{8'h10, 8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00, 8'h10,
    8'h00, 8'h10, 8'h00, 8'h10, 8'h10, 8'h20, 8'h20, 8'h00, 8'h00, 8'h08};

  ptd_trap_unit u_dut (.ref_clk(ref_clk), .rst(rst), .dacc_valid(dacc_valid),
    .dacc_word(dacc_word), .dacc_addr(dacc_addr), .dacc_mac_x(dacc_mac_x),
    .dacc_mac_y(dacc_mac_y), .pacc_valid(pacc_valid), .pacc_addr(pacc_addr),
    .ifetch_valid(ifetch_valid), .ifetch_addr(ifetch_addr), .bra_lit_valid(bra_lit_valid),
    .bra_lit_target(bra_lit_target), .pc_exec_valid(pc_exec_valid), .pc_value(pc_value),
    .sp_load_valid(sp_load_valid), .sp_value(sp_value),
    .stack_limit_register(stack_limit_register), .osc_fail(osc_fail), .arith_err(arith_err),
    .trap_ack(trap_ack), .ack_level(ack_level), .trap_done(trap_done),
    .conflict_flag_clr(conflict_flag_clr), .trap_pending(trap_pending),
    .service_req(service_req), .service_level(service_level), .core_hold(core_hold),
    .conflict_reset(conflict_reset), .reset_control_register(reset_control_register));
  ptd_core_model u_core (.ref_clk(ref_clk), .rst(rst), .auto_ack(auto_ack),
    .service_req(service_req), .service_level(service_level), .trap_ack(trap_ack),
    .ack_level(ack_level), .trap_done(trap_done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [3:0] lvl(input logic [7:0] p);
    lvl = LVL_BASE;
    for (int i = 0; i < 8; i++) if (p[i]) lvl = 4'(8 + i);
  endfunction : lvl

  task automatic do_rst;
    @(negedge ref_clk);
    rst = 1'b1;
    auto_ack = 1'b0;
    @(negedge ref_clk);
    rst = 1'b0;
  endtask : do_rst

  task automatic set_cause(input int k, input logic [23:0] a);
    case (k)
      0, 1: begin
        dacc_valid = 1'b1;
        dacc_word = (k == 0);
        dacc_addr = a[15:0];
      end
      2, 3: begin
        dacc_valid = 1'b1;
        dacc_mac_x = (k == 2);
        dacc_mac_y = (k == 3);
        dacc_addr = a[15:0];
      end
      4: begin pacc_valid = 1'b1; pacc_addr = a; end
      5: begin ifetch_valid = 1'b1; ifetch_addr = a; end
      6: begin bra_lit_valid = 1'b1; bra_lit_target = a; end
      7: begin pc_exec_valid = 1'b1; pc_value = a; end
      8: begin sp_load_valid = 1'b1; sp_value = a[15:0]; end
      default: arith_err = 1'b1;
    endcase
  endtask : set_cause

  task automatic clr_all;
    {dacc_valid, dacc_word, dacc_mac_x, dacc_mac_y, pacc_valid, ifetch_valid} = '0;
    {bra_lit_valid, pc_exec_valid, sp_load_valid, arith_err, conflict_flag_clr} = '0;
  endtask : clr_all

  task automatic fire(input int k, input logic [23:0] a);
    @(negedge ref_clk);
    set_cause(k, a);
    @(negedge ref_clk);
    clr_all();
  endtask : fire

  task automatic wait_pend(input logic [7:0] exp);
    int n;
    n = 0;
    while (trap_pending !== exp && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(trap_pending), 16'(exp), "pending");
  endtask : wait_pend

  ////////////////////////////////////////////////////////////////////////////
  // each cause alone; all but branch literal, pc change and arithmetic error also with a legal neighbour that must not trap
  task automatic t_causes;
    for (int i = 0; i < 19; i++) begin
      do_rst();
      fire(kk[i], aa[i]);
      chk(16'(trap_pending), 16'(pp[i]), "cause");
      chk(16'(service_level), 16'(lvl(pp[i])), "level");
      chk(16'(core_hold), 16'(|pp[i][7:4]), "hold");
      auto_ack = 1'b1;
      wait_pend(8'h00);
      chk(16'(core_hold), 16'h0000, "hold after ack");
    end
  endtask : t_causes

  // three causes in one cycle: highest first, others stay, no conflict
  task automatic t_same_cycle;
    do_rst();
    @(negedge ref_clk);
    set_cause(0, 24'h001001);
    set_cause(8, 24'h0007FE);
    set_cause(9, 24'h0);
    @(negedge ref_clk);
    clr_all();
    chk(16'(trap_pending), 16'h0038, "joint");
    chk(16'(service_level), 16'(LVL_STACK), "joint level");
    auto_ack = 1'b1;
    wait_pend(8'h18);
    wait_pend(8'h00);
    chk(reset_control_register, 16'h0000, "no conflict");
  endtask : t_same_cycle

  // oscillator trap, then a lower hard trap forces the conflict reset
  task automatic t_conflict;
    do_rst();
    @(negedge ref_clk);
    osc_fail = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(16'(trap_pending), 16'h0040, "osc");
    chk(16'(service_level), 16'(LVL_OSC), "osc level");
    fire(8, 24'h000700);
    chk(16'(conflict_reset), 16'h0001, "reset pulse");
    chk(reset_control_register, 16'h8000, "flag");
    chk(16'({trap_pending, core_hold}), 16'h0000, "cleared");
    @(negedge ref_clk);
    chk(16'(conflict_reset), 16'h0000, "pulse end");
    conflict_flag_clr = 1'b1;
    osc_fail = 1'b0;
    @(negedge ref_clk);
    clr_all();
    chk(reset_control_register, 16'h0000, "flag clear");
  endtask : t_conflict

  // oscillator trap acknowledged but still in service when a stack trap arrives
  task automatic t_ack_conflict;
    do_rst();
    @(negedge ref_clk);
    osc_fail = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(16'(trap_pending), 16'h0040, "osc again");
    auto_ack = 1'b1;
    wait_pend(8'h00);
    set_cause(8, 24'h000700);
    @(negedge ref_clk);
    clr_all();
    auto_ack = 1'b0;
    chk(16'(conflict_reset), 16'h0001, "in-service conflict");
    chk(reset_control_register, 16'h8000, "in-service flag");
    osc_fail = 1'b0;
    @(negedge ref_clk);
    chk(16'(conflict_reset), 16'h0000, "in-service pulse end");
  endtask : t_ack_conflict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    auto_ack = 1'b0;
    osc_fail = 1'b0;
    clr_all();
    {dacc_addr, sp_value} = '0;
    {pacc_addr, ifetch_addr, bra_lit_target, pc_value} = '0;
    stack_limit_register = 16'h0A00;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    t_causes();
    t_same_cycle();
    t_conflict();
    t_ack_conflict();
    wrap_up();
  end
endmodule : tb
